// *** rtl/spgc_pkg.sv ***
// package with register map, field positions, reset values and timing constants for the port-four global control bank
//
// Contract
// - bit 7 enables port-b back pressure
// - bit 6 selects half duplex when set
// - duplex reset value follows duplex strap
// - bit 5 enables full-duplex flow control
// - flow control reset follows its strap
// - bit 4 selects 10Mbps, clear 100Mbps
// - speed reset value follows speed strap
// - bit 3 replaces null VID by port VID
// - 11-bit storm limit in 64-byte blocks, default 0x4A
// - storm period 50ms at 100BT, 500ms at 10BT
// - clock-edge bit 7 picks third MAC edge
// - clock-edge bit 6 picks fourth MAC edge
package spgc_pkg;

	// register offsets
	localparam logic [7:0] SPGC_OFS_PORT_B_CTRL = 8'h06;
	localparam logic [7:0] SPGC_OFS_STORM_LOW = 8'h07;
	localparam logic [7:0] SPGC_OFS_TEST_A = 8'h08;
	localparam logic [7:0] SPGC_OFS_TEST_B = 8'h09;
	localparam logic [7:0] SPGC_OFS_TEST_C = 8'h0A;
	localparam logic [7:0] SPGC_OFS_CLK_EDGE = 8'h0B;

	// field positions in port_b_mac_control
	localparam int SPGC_BIT_BACKPRESS = 7;
	localparam int SPGC_BIT_HALF_DUPLEX = 6;
	localparam int SPGC_BIT_FLOW_CTRL = 5;
	localparam int SPGC_BIT_SPEED_10 = 4;
	localparam int SPGC_BIT_NULL_VID = 3;

	// field positions in clock_edge_and_misc_control
	localparam int SPGC_BIT_EDGE_A = 7;
	localparam int SPGC_BIT_EDGE_B = 6;
	localparam int SPGC_BIT_PHY_SAVE = 3;
	localparam int SPGC_BIT_LED_MODE = 1;
	localparam int SPGC_BIT_RD_EDGE = 0;

	// reset values
	localparam logic [2:0] SPGC_RST_STORM_HIGH = 3'h0;
	localparam logic [7:0] SPGC_RST_STORM_LOW = 8'h4A;
	localparam logic [7:0] SPGC_RST_TEST_A = 8'h00;
	localparam logic [7:0] SPGC_RST_TEST_B = 8'h4C;
	localparam logic [7:0] SPGC_RST_TEST_C = 8'h00;

	// storm period timing at 40 MHz
	localparam int SPGC_CLK_HZ = 40000000;
	localparam int SPGC_PERIOD_100_MS = 50;
	localparam int SPGC_PERIOD_10_MS = 500;
	localparam int SPGC_PERIOD_100_CYC = SPGC_CLK_HZ / 1000 * SPGC_PERIOD_100_MS;
	localparam int SPGC_PERIOD_10_CYC = SPGC_CLK_HZ / 1000 * SPGC_PERIOD_10_MS;
	localparam int SPGC_BLOCK_BYTES = 64;

	// management port write/read request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spgc_req_t;

	// decoded port-b mac settings
	typedef struct packed {
		logic back_pressure;
		logic half_duplex;
		logic flow_ctrl;
		logic speed_10;
		logic null_vid_replace;
		logic edge_neg_a;
		logic edge_neg_b;
		logic phy_power_save;
		logic led_mode;
		logic read_edge;
	} spgc_cfg_t;

endpackage : spgc_pkg

// *** rtl/spgc_global_ctrl.sv ***
// register bank for port-b mac control, broadcast storm limiting and rmii clock edges
`timescale 1ns/1ps
module spgc_global_ctrl #(
	parameter int PERIOD_100_CYC = spgc_pkg::SPGC_PERIOD_100_CYC,
	parameter int PERIOD_10_CYC = spgc_pkg::SPGC_PERIOD_10_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// strap pins, asynchronous to clk
	input wire logic duplex_strap_pin,
	input wire logic flow_ctrl_strap_pin,
	input wire logic speed_strap_pin,
	input wire logic led_strap_pin,
	// management port register access
	input wire spgc_pkg::spgc_req_t mgmt_req,
	output logic [7:0] mgmt_rdata,
	output logic mgmt_rvalid,
	// broadcast data from port b ingress, one pulse per received byte
	input wire logic bcast_byte,
	output logic bcast_drop,
	// decoded settings to the mac
	output spgc_pkg::spgc_cfg_t cfg
);
	import spgc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// strap synchronisers
	logic [3:0] strap_s1_reg; // first stage, read only by stage two
	logic [3:0] strap_s2_reg;
	logic [3:0] strap_s3_reg;
	logic [3:0] strap_val_reg; // filtered strap level
	logic [3:0] strap_raw;

	assign strap_raw = {led_strap_pin, speed_strap_pin, flow_ctrl_strap_pin, duplex_strap_pin};

	// three flops; a change is taken only when stages two and three agree
	always_ff @(posedge clk) begin
		if (clk_en) begin
			strap_s1_reg <= strap_raw;
			strap_s2_reg <= strap_s1_reg;
			strap_s3_reg <= strap_s2_reg;
		end
	end

	// filtered level tracks pins during reset as well, so the release loads a settled value
	always_ff @(posedge clk) begin
		if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				if (strap_s2_reg[i] == strap_s3_reg[i]) begin
					strap_val_reg[i] <= strap_s3_reg[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] port_b_mac_control_reg;
	logic [2:0] storm_high_reg; // bits [10:8] of the limit
	logic [7:0] storm_limit_low_reg;
	logic edge_a_reg;
	logic edge_b_reg;
	logic phy_save_reg;
	logic led_mode_reg;
	logic rd_edge_reg;
	logic wr_hit_ctrl;
	logic wr_hit_low;
	logic wr_hit_edge;

	assign wr_hit_ctrl = mgmt_req.wr && (mgmt_req.addr == SPGC_OFS_PORT_B_CTRL);
	assign wr_hit_low = mgmt_req.wr && (mgmt_req.addr == SPGC_OFS_STORM_LOW);
	assign wr_hit_edge = mgmt_req.wr && (mgmt_req.addr == SPGC_OFS_CLK_EDGE);

	// port-b control: straps give the reset value of duplex, flow control and speed
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (!rst_n) begin
				port_b_mac_control_reg <= 8'h00;
				port_b_mac_control_reg[SPGC_BIT_HALF_DUPLEX] <= strap_val_reg[0];
				port_b_mac_control_reg[SPGC_BIT_FLOW_CTRL] <= strap_val_reg[1];
				port_b_mac_control_reg[SPGC_BIT_SPEED_10] <= strap_val_reg[2];
			end else if (wr_hit_ctrl) begin
				port_b_mac_control_reg <= mgmt_req.wdata;
			end
		end
	end

	// storm high bits live in the low three bits of the control register
	assign storm_high_reg = port_b_mac_control_reg[2:0];

	// storm limit low byte
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (!rst_n) begin
				storm_limit_low_reg <= SPGC_RST_STORM_LOW;
			end else if (wr_hit_low) begin
				storm_limit_low_reg <= mgmt_req.wdata;
			end
		end
	end

	// clock-edge and misc; reserved bits are not stored and read zero
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (!rst_n) begin
				edge_a_reg <= 1'b0;
				edge_b_reg <= 1'b0;
				phy_save_reg <= 1'b0;
				led_mode_reg <= strap_val_reg[3];
				rd_edge_reg <= 1'b0;
			end else if (wr_hit_edge) begin
				edge_a_reg <= mgmt_req.wdata[SPGC_BIT_EDGE_A];
				edge_b_reg <= mgmt_req.wdata[SPGC_BIT_EDGE_B];
				phy_save_reg <= mgmt_req.wdata[SPGC_BIT_PHY_SAVE];
				led_mode_reg <= mgmt_req.wdata[SPGC_BIT_LED_MODE];
				rd_edge_reg <= mgmt_req.wdata[SPGC_BIT_RD_EDGE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path, one cycle after the request
	logic [7:0] rdata_next;

	// unmapped offsets read zero
	always_comb begin
		rdata_next = 8'h00;
		case (mgmt_req.addr)
			SPGC_OFS_PORT_B_CTRL: begin
				rdata_next = port_b_mac_control_reg;
			end
			SPGC_OFS_STORM_LOW: begin
				rdata_next = storm_limit_low_reg;
			end
			SPGC_OFS_TEST_A: begin
				rdata_next = SPGC_RST_TEST_A;
			end
			SPGC_OFS_TEST_B: begin
				rdata_next = SPGC_RST_TEST_B;
			end
			SPGC_OFS_TEST_C: begin
				rdata_next = SPGC_RST_TEST_C;
			end
			SPGC_OFS_CLK_EDGE: begin
				rdata_next = 8'h00;
				rdata_next[SPGC_BIT_EDGE_A] = edge_a_reg;
				rdata_next[SPGC_BIT_EDGE_B] = edge_b_reg;
				rdata_next[SPGC_BIT_PHY_SAVE] = phy_save_reg;
				rdata_next[SPGC_BIT_LED_MODE] = led_mode_reg;
				rdata_next[SPGC_BIT_RD_EDGE] = rd_edge_reg;
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	// registered read data and its valid pulse
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (!rst_n) begin
				mgmt_rdata <= 8'h00;
				mgmt_rvalid <= 1'b0;
			end else begin
				mgmt_rvalid <= mgmt_req.rd;
				if (mgmt_req.rd) begin
					mgmt_rdata <= rdata_next;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// broadcast storm limiter
	logic [24:0] period_cnt_reg; // holds up to 500ms of cycles
	logic [24:0] period_len;
	logic period_end;
	logic [5:0] byte_cnt_reg; // bytes within the current 64-byte block
	logic [10:0] block_cnt_reg; // blocks accepted this period
	logic [10:0] storm_limit;
	logic over_limit;

	assign storm_limit = {storm_high_reg, storm_limit_low_reg};
	// period follows the port speed bit
	assign period_len = port_b_mac_control_reg[SPGC_BIT_SPEED_10] ? 25'(PERIOD_10_CYC) : 25'(PERIOD_100_CYC);
	assign period_end = (period_cnt_reg >= period_len - 25'd1);
	assign over_limit = (block_cnt_reg >= storm_limit);

	// period timer; a speed change applies its new length to the running period at once rather than waiting
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (!rst_n || period_end) begin
				period_cnt_reg <= 25'd0;
			end else begin
				period_cnt_reg <= period_cnt_reg + 25'd1;
			end
		end
	end

	// count 64-byte blocks; the period end wins over a byte arriving in the period's last cycle
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (!rst_n || period_end) begin
				byte_cnt_reg <= 6'd0;
				block_cnt_reg <= 11'd0;
			end else if (bcast_byte && !over_limit) begin
				byte_cnt_reg <= byte_cnt_reg + 6'd1;
				if (byte_cnt_reg == 6'(SPGC_BLOCK_BYTES - 1)) begin
					block_cnt_reg <= block_cnt_reg + 11'd1;
				end
			end
		end
	end

	// drop is a handshake output: combinational against the byte strobe
	assign bcast_drop = bcast_byte && over_limit;

	////////////////////////////////////////////////////////////////////////
	// decoded settings
	always_comb begin
		cfg.back_pressure = port_b_mac_control_reg[SPGC_BIT_BACKPRESS];
		cfg.half_duplex = port_b_mac_control_reg[SPGC_BIT_HALF_DUPLEX];
		cfg.flow_ctrl = port_b_mac_control_reg[SPGC_BIT_FLOW_CTRL];
		cfg.speed_10 = port_b_mac_control_reg[SPGC_BIT_SPEED_10];
		cfg.null_vid_replace = port_b_mac_control_reg[SPGC_BIT_NULL_VID];
		cfg.edge_neg_a = edge_a_reg;
		cfg.edge_neg_b = edge_b_reg;
		cfg.phy_power_save = phy_save_reg;
		cfg.led_mode = led_mode_reg;
		cfg.read_edge = rd_edge_reg;
	end

endmodule // spgc_global_ctrl

// *** tb/spgc_global_ctrl_assertions.sv ***
// checker for the port-four global control bank
`timescale 1ns/1ps
module spgc_global_ctrl_checker import spgc_pkg::*; #(
	parameter int PERIOD_100_CYC = 200,
	parameter int PERIOD_10_CYC = 2000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// straps
	input wire logic duplex_strap_pin,
	input wire logic flow_ctrl_strap_pin,
	input wire logic speed_strap_pin,
	// register port
	input wire spgc_pkg::spgc_req_t mgmt_req,
	input wire logic [7:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	// storm and settings
	input wire logic bcast_byte,
	input wire logic bcast_drop,
	input wire spgc_pkg::spgc_cfg_t cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// taken writes; a frozen clock takes nothing
	wire logic wr_ctl = clk_en && mgmt_req.wr && mgmt_req.addr == 8'h06;
	wire logic wr_edge = clk_en && mgmt_req.wr && mgmt_req.addr == 8'h0B;
	chk_read_answer: assert property (clk_en && mgmt_req.rd |=> mgmt_rvalid)
		else $error("read not answered");
	chk_rvalid_pulse: assert property (clk_en && !mgmt_req.rd |=> !mgmt_rvalid)
		else $error("rvalid without read");
	chk_rdata_hold: assert property (clk_en && !mgmt_req.rd |=> $stable(mgmt_rdata))
		else $error("read data moved");
	chk_duplex_write: assert property (wr_ctl |=> {cfg.back_pressure, cfg.half_duplex} == $past(mgmt_req.wdata[7:6]))
		else $error("duplex bits wrong");
	chk_speed_write: assert property (wr_ctl |=> {cfg.flow_ctrl, cfg.speed_10, cfg.null_vid_replace} == $past(mgmt_req.wdata[5:3]))
		else $error("speed bits wrong");
	chk_edge_write: assert property (wr_edge |=> {cfg.edge_neg_a, cfg.edge_neg_b} == $past(mgmt_req.wdata[7:6]))
		else $error("edge bits wrong");
	chk_strap_load: assert property ($rose(rst_n) && clk_en |-> {cfg.half_duplex, cfg.flow_ctrl, cfg.speed_10} == {duplex_strap_pin, flow_ctrl_strap_pin, speed_strap_pin})
		else $error("strap not loaded");
	chk_test_const: assert property (clk_en && mgmt_req.rd && mgmt_req.addr == 8'h09 |=> mgmt_rdata == 8'h4C)
		else $error("test value wrong");
	chk_reserved_zero: assert property (clk_en && mgmt_req.rd && mgmt_req.addr == 8'h0B |=> mgmt_rdata[5:4] == 2'h0 && !mgmt_rdata[2])
		else $error("reserved bits set");
	chk_drop_cause: assert property (bcast_drop |-> bcast_byte)
		else $error("drop without byte");
	cover property (wr_edge);
	cover property (bcast_drop);
	cover property ($rose(rst_n));
endmodule // spgc_global_ctrl_checker
bind spgc_global_ctrl spgc_global_ctrl_checker #(.PERIOD_100_CYC(PERIOD_100_CYC), .PERIOD_10_CYC(PERIOD_10_CYC)) u_chk (
	.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .duplex_strap_pin(duplex_strap_pin),
	.flow_ctrl_strap_pin(flow_ctrl_strap_pin), .speed_strap_pin(speed_strap_pin), .mgmt_req(mgmt_req),
	.mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .bcast_byte(bcast_byte), .bcast_drop(bcast_drop), .cfg(cfg));

// *** tb/spgc_bcast_src.sv ***
// far-side mac model streaming broadcast bytes
`timescale 1ns/1ps
module spgc_bcast_src (
	// clock
	input wire logic clk,
	// stream request from the bench
	input wire logic en,
	// one byte per cycle while streaming
	output logic bcast_byte = 1'b0
);
	logic en_q = 1'b0; // retimed request, avoids a race with the bench
	// capture on rising edge, launch on falling edge
	always @(posedge clk) en_q <= en;
	always @(negedge clk) bcast_byte <= en_q;
endmodule // spgc_bcast_src

// *** tb/spgc_global_ctrl_tb.sv ***
// self-checking bench for the port-four global control bank
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module spgc_global_ctrl_tb;
	import spgc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic bcast_en = 1'b0;
	logic [2:0] straps = 3'h7; // duplex, flow, speed
	spgc_req_t req = '0;
	logic [7:0] rdata;
	logic rvalid;
	logic bcast_byte;
	logic bcast_drop;
	spgc_cfg_t cfg;
	int num_errors = 0;
	int cmp_count = 0;
	int acc;
	int n;
	always #12.5 clk = ~clk;
	// short periods keep the run brief
	spgc_global_ctrl #(.PERIOD_100_CYC(200), .PERIOD_10_CYC(2000)) u_spgc_global_ctrl (.clk(clk), .rst_n(rst_n),
		.clk_en(clk_en), .duplex_strap_pin(straps[2]), .flow_ctrl_strap_pin(straps[1]), .speed_strap_pin(straps[0]),
		.led_strap_pin(straps[0]), .mgmt_req(req), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
		.bcast_byte(bcast_byte), .bcast_drop(bcast_drop), .cfg(cfg));
	spgc_bcast_src u_spgc_bcast_src (.clk(clk), .en(bcast_en), .bcast_byte(bcast_byte));
	////////////////////////////////////////////////////////////////
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
	endtask
	// one-cycle read strobe, answer checked a cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
		`CHK(rvalid, 1'b1)
		`CHK(rdata, e)
	endtask
	// stream until a period edge, then count accepted bytes and period length
	task automatic measure();
		int k;
		bit seen;
		k = 0;
		seen = 0;
		acc = 0;
		n = 0;
		bcast_en = 1'b1;
		do begin @(negedge clk); #1; k++; end while (bcast_drop !== 1'b1 && k < 9000);
		do begin @(negedge clk); #1; k++; end while (bcast_drop !== 1'b0 && k < 9000);
		do begin
			if (bcast_drop === 1'b0) acc++;
			else seen = 1;
			n++;
			@(negedge clk);
			#1;
			k++;
		end while (!(seen && bcast_drop === 1'b0) && k < 9000);
		bcast_en = 1'b0;
	endtask
	task automatic do_reset(input logic [2:0] s);
		straps = s;
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
	endtask
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog, well beyond the longest storm measurement
	initial begin
		#1000000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		do_reset(3'h7);
		rd(8'h06, 8'h70);
		`CHK(cfg, 10'h1C2)
		rd(8'h07, 8'h4A);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h4C);
		rd(8'h0A, 8'h00);
		rd(8'h0B, 8'h02);
		rd(8'h20, 8'h00);
		wr(8'h06, 8'hF8);
		rd(8'h06, 8'hF8);
		`CHK(cfg[9:5], 5'h1F)
		wr(8'h08, 8'h55);
		rd(8'h08, 8'h00);
		wr(8'h0B, 8'hFF);
		rd(8'h0B, 8'hCB);
		`CHK(cfg[4:3], 2'h3)
		// frozen clock enable must swallow the write
		clk_en = 1'b0;
		wr(8'h06, 8'h00);
		clk_en = 1'b1;
		rd(8'h06, 8'hF8);
		wr(8'h06, 8'h10);
		wr(8'h07, 8'h01);
		measure();
		`CHK(acc, 64)
		`CHK(n, 2000)
		wr(8'h06, 8'h00);
		measure();
		`CHK(acc, 64)
		`CHK(n, 200)
		wr(8'h07, 8'h00);
		bcast_en = 1'b1;
		repeat (3) @(negedge clk);
		// the model launches its byte on this same falling edge, so let it settle first
		#1;
		`CHK(bcast_drop, 1'b1)
		bcast_en = 1'b0;
		do_reset(3'h0);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h4A);
		rd(8'h0B, 8'h00);
		tally_and_finish();
	end
endmodule // spgc_global_ctrl_tb
